/* File: hw/rpm_top.sv */
// reset and power mode sequencer: reset qualification, idle and power-down
`timescale 1ns/1ps
module rpm_top
  import rpm_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                rst_pin_i,
  output logic                     rst_pin_o,
  output logic                     rst_pin_oe,
  input  wire logic                power_control_reg_wr,
  input  wire logic [PWR_W-1:0]    power_control_reg_wdata,
  output logic      [PWR_W-1:0]    power_control_reg_rdata,
  input  wire logic                instr_done,
  input  wire logic                int_enabled_pend,
  input  wire logic                watchdog_timer_ovf,
  output logic                     int_clk,
  output logic                     osc_run,
  output logic                     cpu_halt,
  output logic                     periph_run,
  output logic                     state_hold,
  output logic                     ram_retain_only,
  output logic                     wake_int,
  output logic                     sys_reset
);
  rpm_rst_if rif ();

  rpm_mode_type      mode_q;
  logic [PWR_W-1:0]  pwr_q;
  logic              osc_en_q;
  logic              div_q;
  logic              drv_q;
  logic [CNT_W-1:0]  drv_cnt_q;
  logic              cpu_halt_q;
  logic              periph_run_q;
  logic              state_hold_q;
  logic              ram_only_q;
  logic              wake_q;
  logic              sys_reset_q;
  logic              seq_rst;

  // pin qualifier; it sees our own watchdog drive through the pin too
  rpm_rst_qual u_qual (
    .clk       (clk),
    .rst       (rst),
    .rst_pin_i (rst_pin_i),
    .rif       (rif)
  );

  assign rif.osc_run = osc_en_q;
  // the mode, power control, wake and status registers are cleared by either reset source
  assign seq_rst = rst || rif.qual_rst;

  // oscillator gate: stops in power-down, restarts when the pin goes high
  always_ff @(posedge clk) begin
    if (rst) begin
      osc_en_q <= 1'b1;
    end else if (rif.pin_high) begin
      osc_en_q <= 1'b1; // lets the qualifier count out of power-down
    end else if (mode_q == MODE_RUN && instr_done && pwr_q[PWR_DOWN_BIT]) begin
      osc_en_q <= 1'b0;
    end
  end

  // divide-by-two internal clock, immune to input duty cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= 1'b0;
    end else if (osc_en_q) begin
      div_q <= ~div_q;
    end
  end

  // power control register, written by the CPU while running
  always_ff @(posedge clk) begin
    if (seq_rst) begin
      pwr_q <= PWR_RESET;
    end else if (mode_q == MODE_IDLE && int_enabled_pend) begin
      pwr_q[PWR_IDLE_BIT] <= 1'b0; // hardware clear on wake
    end else if (power_control_reg_wr && mode_q == MODE_RUN) begin
      pwr_q <= power_control_reg_wdata;
    end
  end

  // mode sequencing; power-down takes priority when both bits are set
  always_ff @(posedge clk) begin
    if (seq_rst) begin
      mode_q <= MODE_RUN;
    end else begin
      case (mode_q)
        MODE_RUN: begin
          if (instr_done && pwr_q[PWR_DOWN_BIT]) begin
            mode_q <= MODE_PDOWN;
          end else if (instr_done && pwr_q[PWR_IDLE_BIT]) begin
            mode_q <= MODE_IDLE;
          end
        end
        MODE_IDLE: begin
          if (int_enabled_pend) begin
            mode_q <= MODE_RUN;
          end
        end
        MODE_PDOWN: begin
          mode_q <= MODE_PDOWN; // interrupts cannot wake it
        end
        default: begin
          mode_q <= MODE_RUN;
        end
      endcase
    end
  end

  // one-cycle wake pulse so the CPU vectors to the pending interrupt
  always_ff @(posedge clk) begin
    if (seq_rst) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= (mode_q == MODE_IDLE) && int_enabled_pend;
    end
  end

  // status outputs, registered from the next mode
  always_ff @(posedge clk) begin
    if (seq_rst) begin
      cpu_halt_q   <= 1'b0;
      periph_run_q <= 1'b1;
      state_hold_q <= 1'b0;
      ram_only_q   <= 1'b0;
    end else begin
      case (mode_q)
        MODE_RUN: begin
          cpu_halt_q   <= instr_done && (pwr_q != PWR_RESET);
          periph_run_q <= !(instr_done && pwr_q[PWR_DOWN_BIT]);
          state_hold_q <= instr_done && pwr_q[PWR_IDLE_BIT]
                          && !pwr_q[PWR_DOWN_BIT];
          ram_only_q   <= instr_done && pwr_q[PWR_DOWN_BIT];
        end
        MODE_IDLE: begin
          cpu_halt_q   <= !int_enabled_pend;
          periph_run_q <= 1'b1;
          state_hold_q <= !int_enabled_pend;
          ram_only_q   <= 1'b0;
        end
        MODE_PDOWN: begin
          cpu_halt_q   <= 1'b1;
          periph_run_q <= 1'b0;
          state_hold_q <= 1'b0;
          ram_only_q   <= 1'b1;
        end
        default: begin
          cpu_halt_q   <= 1'b0;
          periph_run_q <= 1'b1;
          state_hold_q <= 1'b0;
          ram_only_q   <= 1'b0;
        end
      endcase
    end
  end

  // watchdog overflow drives the reset pin high for a fixed pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      drv_q     <= 1'b0;
      drv_cnt_q <= '0;
    end else if (drv_q) begin
      if (drv_cnt_q == CNT_W'(WDT_PULSE_CYC - 1)) begin
        drv_q     <= 1'b0;
        drv_cnt_q <= '0;
      end else begin
        drv_cnt_q <= drv_cnt_q + CNT_W'(1);
      end
    end else if (watchdog_timer_ovf) begin
      drv_q <= 1'b1;
    end
  end

  // chip-wide reset, registered to keep the output glitch-free
  always_ff @(posedge clk) begin
    if (rst) begin
      sys_reset_q <= 1'b1;
    end else begin
      sys_reset_q <= rif.qual_rst;
    end
  end

  assign rst_pin_o               = drv_q; // drives high only
  assign rst_pin_oe              = drv_q;
  assign power_control_reg_rdata = pwr_q;
  assign int_clk                 = div_q;
  assign osc_run                 = osc_en_q;
  assign cpu_halt                = cpu_halt_q;
  assign periph_run              = periph_run_q;
  assign state_hold              = state_hold_q;
  assign ram_retain_only         = ram_only_q;
  assign wake_int                = wake_q;
  assign sys_reset               = sys_reset_q;
endmodule : rpm_top

/* File: include/rpm_pkg.sv */
// constants and types for the reset and power mode controller
package rpm_pkg;
  // clock and machine-cycle timing; clk is the oscillator input itself
  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned OSC_PER_MC      = 12;
  localparam int unsigned RST_MIN_MC      = 2;
  localparam int unsigned RST_MIN_OSC     = 24;
  localparam int unsigned RST_QUAL_CYC    = (RST_MIN_OSC < 1) ? 1 : RST_MIN_OSC;
  // watchdog reset pulse driven onto the reset pin, in machine cycles
  localparam int unsigned WDT_PULSE_MC    = 2;
  localparam int unsigned WDT_PULSE_CYC   = WDT_PULSE_MC * OSC_PER_MC;
  localparam int unsigned CNT_W           = 6;
  // power control register field positions and reset value
  localparam int unsigned PWR_IDLE_BIT    = 0;
  localparam int unsigned PWR_DOWN_BIT    = 1;
  localparam int unsigned PWR_W           = 2;
  localparam logic [1:0]  PWR_RESET       = 2'h0;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_IDLE,
    MODE_PDOWN
  } rpm_mode_type;
endpackage : rpm_pkg

/* File: include/rpm_rst_if.sv */
// qualified reset signals between the pin qualifier and the sequencer
`timescale 1ns/1ps
interface rpm_rst_if;
  logic osc_run;   // oscillator running, counting allowed
  logic pin_high;  // debounced reset pin level
  logic qual_rst;  // reset pin held long enough

  modport qual (input osc_run, output pin_high, output qual_rst);
  modport seq  (output osc_run, input pin_high, input qual_rst);
endinterface : rpm_rst_if

/* File: hw/rpm_rst_qual.sv */
// reset pin synchroniser and minimum-width qualifier
`timescale 1ns/1ps
module rpm_rst_qual
  import rpm_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic rst_pin_i,
  rpm_rst_if.qual   rif
);
  logic              sync1_q;
  logic              sync2_q;
  logic              sync3_q;
  logic              level_q;
  logic [CNT_W-1:0]  cnt_q;
  logic              qual_q;

  // three-stage synchroniser; first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      sync1_q <= rst_pin_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // level changes only once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      level_q <= 1'b0;
    end else if (sync2_q == sync3_q) begin
      level_q <= sync3_q;
    end
  end

  // count oscillator periods of high pin while oscillator runs
  always_ff @(posedge clk) begin
    if (rst || !level_q || !rif.osc_run) begin
      cnt_q  <= '0; // short pulses never reach the threshold
      qual_q <= 1'b0;
    end else if (cnt_q == CNT_W'(RST_QUAL_CYC - 1)) begin
      qual_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  assign rif.pin_high = level_q;
  assign rif.qual_rst = qual_q;
endmodule : rpm_rst_qual

/* File: test/rpm_top_props.sv */
// concurrent checks on the reset and power mode sequencer ports
`timescale 1ns/1ps
module rpm_top_props (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       rst_pin_i,
  input wire logic       rst_pin_oe,
  input wire logic       power_control_reg_wr,
  input wire logic [1:0] power_control_reg_rdata,
  input wire logic       instr_done,
  input wire logic       int_enabled_pend,
  input wire logic       watchdog_timer_ovf,
  input wire logic       int_clk,
  input wire logic       osc_run,
  input wire logic       cpu_halt,
  input wire logic       periph_run,
  input wire logic       state_hold,
  input wire logic       ram_retain_only,
  input wire logic       wake_int,
  input wire logic       sys_reset
);
  logic [5:0] hi_q;
  logic       pin_q;
  // length of the latest pin-high run; held while low so a late rise still sees it
  // cleared in reset, so a pin already high at power-on counts from the release
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_q <= 1'b0;
      hi_q  <= 6'h0;
    end else begin
      pin_q <= rst_pin_i;
      if (rst_pin_i && !pin_q) hi_q <= 6'h1;
      else if (rst_pin_i && hi_q != 6'h3f) hi_q <= hi_q + 6'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_reset_qual: assert property ($rose(sys_reset) |-> hi_q >= 6'h18)
    else $error("reset from a short pin pulse");
  a_int_clk: assert property (osc_run && $past(osc_run) && $past(osc_run, 2) && !sys_reset
    && !$past(rst) |-> int_clk != $past(int_clk)) else $error("int_clk not toggling");
  a_idle_entry: assert property (instr_done && !cpu_halt && !sys_reset
    && power_control_reg_rdata == 2'h1 |=> cpu_halt && state_hold && periph_run)
    else $error("idle entry wrong");
  a_idle_wake: assert property (state_hold && int_enabled_pend && !sys_reset |=> wake_int
    && !cpu_halt && !power_control_reg_rdata[0] ##1 !wake_int) else $error("idle wake wrong");
  a_pdown_entry: assert property (instr_done && !cpu_halt && !sys_reset
    && power_control_reg_rdata[1] |=> cpu_halt && !osc_run && ram_retain_only && !periph_run)
    else $error("power-down entry wrong");
  a_pdown_held: assert property ((ram_retain_only && !rst_pin_i) [*6] |=> ram_retain_only)
    else $error("power-down left without reset");
  a_write_refused: assert property (power_control_reg_wr && cpu_halt && !int_enabled_pend
    && !sys_reset |=> $stable(power_control_reg_rdata)) else $error("write taken while halted");
  a_wdt_pulse: assert property (watchdog_timer_ovf && !rst_pin_oe |=> rst_pin_oe
    ##23 rst_pin_oe ##1 !rst_pin_oe) else $error("watchdog pulse length wrong");
  a_reset_run: assert property (sys_reset ##1 sys_reset |-> !cpu_halt && periph_run
    && power_control_reg_rdata == 2'h0) else $error("mode not run during reset");
  c_wake: cover property (wake_int);
  c_pdown: cover property ($rose(ram_retain_only));
  c_reset: cover property ($rose(sys_reset));
endmodule : rpm_top_props

bind rpm_top rpm_top_props u_props (.clk, .rst, .rst_pin_i, .rst_pin_oe, .power_control_reg_wr,
  .power_control_reg_rdata, .instr_done, .int_enabled_pend, .watchdog_timer_ovf, .int_clk,
  .osc_run, .cpu_halt, .periph_run, .state_hold, .ram_retain_only, .wake_int, .sys_reset);

/* File: test/rpm_rst_src.sv */
// external reset source on the reset pin, wired-or with the device drive
`timescale 1ns/1ps
module rpm_rst_src (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [7:0] len,
  input  wire logic       drv_o,
  input  wire logic       drv_oe,
  output logic            pin
);
  logic [7:0] cnt_q;
  // hold the pin high for len cycles, short or long as asked
  always_ff @(posedge clk) begin
    if (go) cnt_q <= len;
    else if (cnt_q != 8'h0) cnt_q <= cnt_q - 8'h1;
  end
  // pin pulled low when nobody drives it
  assign pin = (cnt_q != 8'h0) | (drv_oe & drv_o);
endmodule : rpm_rst_src

/* File: test/rpm_top_tb_top.sv */
// self-checking bench for the reset and power mode sequencer
`timescale 1ns/1ps
module rpm_top_tb_top;
  import rpm_pkg::*;
  logic clk = 1'b0, rst = 1'b1, go = 1'b1, wr = 1'b0, done = 1'b0, pend = 1'b0, ovf = 1'b0;
  logic [7:0] len = 8'h40;
  logic [1:0] wdata = 2'h0;
  wire logic pin, pin_o, pin_oe, ick, osc, halt, prun, hold, ret, wake, srst;
  wire logic [1:0] rdata;
  int error_cnt = 0, checked = 0;
  // 40 MHz oscillator
  always #12.5 clk = ~clk;
  rpm_top uut (.clk, .rst, .rst_pin_i(pin), .rst_pin_o(pin_o), .rst_pin_oe(pin_oe),
    .power_control_reg_wr(wr), .power_control_reg_wdata(wdata), .power_control_reg_rdata(rdata),
    .instr_done(done), .int_enabled_pend(pend), .watchdog_timer_ovf(ovf), .int_clk(ick),
    .osc_run(osc), .cpu_halt(halt), .periph_run(prun), .state_hold(hold),
    .ram_retain_only(ret), .wake_int(wake), .sys_reset(srst));
  rpm_rst_src u_src (.clk, .go, .len, .drv_o(pin_o), .drv_oe(pin_oe), .pin);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // one-cycle request on the chosen inputs, outputs looked at after the taking edge
  task automatic drive(input logic w, d, p, o, input logic [1:0] v);
    @(posedge clk);
    {wr, done, pend, ovf, wdata} <= {w, d, p, o, v};
    @(posedge clk);
    {wr, done, pend, ovf} <= 4'h0;
    #1;
  endtask : drive
  task automatic wait_rst();
    for (int i = 0; i < 200 && srst !== 1'b0; i++) tick(1);
  endtask : wait_rst
  // pin held n cycles by the outside source; exp says whether a reset follows
  task automatic pin_rst(input int n, input logic exp);
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    {go, len} <= {1'b1, 8'(n)};
    @(posedge clk);
    go <= 1'b0;
    repeat (n + 12) begin
      tick(1);
      if (srst === 1'b1) seen = 1'b1;
    end
    chk(seen, exp);
    wait_rst();
  endtask : pin_rst
  // the power-on pin pulse qualifies as a reset; no request until it has ended
  task automatic t_power_on();
    logic b;
    tick(2);
    for (int i = 0; i < 100 && srst !== 1'b1; i++) tick(1);
    chk(srst, 1);
    wait_rst();
    chk(srst, 0);
    chk({pin_oe, pin_o, halt, osc, rdata}, {4'h1, PWR_RESET});
    b = ick;
    tick(1);
    chk(ick, !b);
  endtask : t_power_on
  task automatic t_idle();
    drive(1, 0, 0, 0, 2'h1);
    chk(rdata, 2'h1);
    drive(0, 1, 0, 0, 2'h0);
    chk({halt, hold, prun}, 3'h7);
    drive(1, 0, 0, 0, 2'h2);
    chk(rdata, 2'h1);
    drive(0, 0, 1, 0, 2'h0);
    chk({wake, halt, rdata}, 4'h8);
    tick(1);
    chk(wake, 0);
    drive(1, 0, 0, 0, 2'h1);
    drive(0, 1, 0, 0, 2'h0);
    pin_rst(40, 1);
    chk({halt, hold, rdata}, 4'h0);
  endtask : t_idle
  task automatic t_pdown();
    logic b;
    drive(1, 0, 0, 0, 2'h2);
    drive(0, 1, 0, 0, 2'h0);
    chk({osc, ret, prun}, 3'h2);
    b = ick;
    drive(0, 0, 1, 0, 2'h0);
    tick(4);
    chk({halt, ick}, {1'b1, b});
    pin_rst(40, 1);
    chk({osc, ret, halt}, 3'h4);
  endtask : t_pdown
  task automatic t_wdt();
    int n;
    n = 0;
    pin_rst(20, 0);
    drive(0, 0, 0, 1, 2'h0);
    chk(pin_o, 1);
    repeat (30) begin
      if (pin_oe === 1'b1) n++;
      tick(1);
    end
    chk(n, WDT_PULSE_CYC);
  endtask : t_wdt
  task automatic tally_and_finish();
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    @(posedge clk);
    go <= 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_power_on();
    t_idle();
    t_pdown();
    t_wdt();
    tally_and_finish();
  end
endmodule : rpm_top_tb_top
